// *** rtl/tsb_irq.sv ***
// Transmit slip buffer with slip detection, status, enables and interrupt
// Functional notes
// RQ1 - Bit 7 read/write, reset 0, enables the buffer full interrupt.
// RQ2 - Write into full buffer deletes one whole frame, sets full and slip status.
// RQ3 - Bit 6 read/write, reset 0, enables the buffer empty interrupt.
// RQ4 - Read from empty buffer repeats one whole frame, sets empty and slip status.
// RQ5 - Bit 5 read/write, reset 0, enables slip interrupt from deletion or repetition.
// RQ6 - Enable bits 4 to 0 reserved, no function, read zero.
// RQ7 - Status bits record events since last status read, clear on that read.
// RQ8 - Software writes zeros to reserved bits and ignores them on read.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module tsb_irq
	import tsb_pkg::*;
#(
	parameter int FRAME = TSB_FRAME_OCTETS,
	parameter int DEPTH = TSB_DEPTH
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// AXI4-Lite write address and data
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Transmit data path: writer side and line side
	input  wire logic [7:0]  tx_wr_data,
	input  wire logic        tx_wr_strobe,
	input  wire logic        tx_rd_strobe,
	output logic [7:0]       tx_rd_data,
	// Interrupt
	output logic             irq
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
	localparam logic [AW:0] FRAME_C = (AW+1)'(FRAME);

	logic [7:0]    mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   fill;
	logic [7:0]    enable;
	logic [7:0]    status;
	logic          full;
	logic          empty;
	logic          ev_full;
	logic          ev_empty;
	logic          aw_held;
	logic          w_held;
	logic [15:0]   aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic          wr_go;
	logic          rd_go;
	logic          status_rd;

	function automatic logic [AW-1:0] wrap_add(input logic [AW-1:0] p, input logic [AW:0] n);
		logic [AW:0] s;
		s = {1'b0, p} + n;
		if (s >= DEPTH_C)
			s = s - DEPTH_C;
		return s[AW-1:0];
	endfunction

	function automatic logic [AW-1:0] wrap_sub(input logic [AW-1:0] p, input logic [AW:0] n);
		logic [AW:0] s;
		s = {1'b0, p} + DEPTH_C - n;
		if (s >= DEPTH_C)
			s = s - DEPTH_C;
		return s[AW-1:0];
	endfunction

	// Enable register is the only writable word
	function automatic logic hits_enable(input logic [15:0] a);
		return a == TSB_ADDR_ENABLE_BYTE;
	endfunction

	assign full     = (fill == DEPTH_C);
	assign empty    = (fill == '0);
	assign ev_full  = tx_wr_strobe && full;    // RQ2
	assign ev_empty = tx_rd_strobe && empty;   // RQ4

	// Buffer storage; a write into a full buffer still lands after the drop
	always_ff @(posedge clk) begin
		if (tx_wr_strobe)
			mem[wr_ptr] <= tx_wr_data;
	end

	// Pointers and fill; overflow drops the oldest frame, underflow replays the last
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
			tx_rd_data <= 8'h00;
		end else begin
			if (tx_wr_strobe)
				wr_ptr <= wrap_add(wr_ptr, (AW+1)'(1));
			if (ev_full) begin
				// A read in the same cycle takes the octet after the dropped frame
				rd_ptr <= wrap_add(rd_ptr, FRAME_C + (AW+1)'(tx_rd_strobe ? 1 : 0)); // RQ2
				fill   <= fill - FRAME_C + (AW+1)'(tx_rd_strobe ? 0 : 1);
				if (tx_rd_strobe)
					tx_rd_data <= mem[wrap_add(rd_ptr, FRAME_C)];
			end else if (ev_empty) begin
				tx_rd_data <= mem[wrap_sub(rd_ptr, FRAME_C)];         // RQ4
				rd_ptr     <= wrap_add(wrap_sub(rd_ptr, FRAME_C), (AW+1)'(1));
				fill       <= FRAME_C - (AW+1)'(1) + (AW+1)'(tx_wr_strobe ? 1 : 0);
			end else begin
				if (tx_rd_strobe) begin
					tx_rd_data <= mem[rd_ptr];
					rd_ptr     <= wrap_add(rd_ptr, (AW+1)'(1));
				end
				fill <= fill + (AW+1)'(tx_wr_strobe ? 1 : 0) - (AW+1)'(tx_rd_strobe ? 1 : 0);
			end
		end
	end

	// AXI write channel capture, in either order
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 16'h0000;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go)
				w_held <= 1'b0;
		end
	end

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_go         = aw_held && w_held && !s_axi_bvalid;

	// Enable register; reserved bits never stored
	always_ff @(posedge clk) begin
		if (sys_rst)
			enable <= TSB_ENABLE_RESET;                     // RQ1 RQ3 RQ5
		else if (wr_go && hits_enable(aw_addr) && w_strb[0])
			enable <= w_data[7:0] & TSB_ENABLE_WMASK;       // RQ1 RQ3 RQ5 RQ6
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= TSB_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= hits_enable(aw_addr) ? TSB_RESP_OKAY : TSB_RESP_SLVERR;
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// AXI read channel, one cycle answer
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go         = s_axi_arvalid && s_axi_arready;
	assign status_rd     = rd_go && s_axi_araddr == TSB_ADDR_STATUS;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= TSB_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= TSB_RESP_OKAY;
			case (s_axi_araddr)
				TSB_ADDR_ENABLE_BYTE: s_axi_rdata <= {24'h0, enable};
				TSB_ADDR_STATUS:      s_axi_rdata <= {24'h0, status};
				TSB_ADDR_FILL:        s_axi_rdata <= 32'(fill);
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= TSB_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Sticky status; a new event beats the read that clears it
	always_ff @(posedge clk) begin
		if (sys_rst)
			status <= TSB_STATUS_RESET;
		else begin
			if (status_rd)
				status <= 8'h00;                                  // RQ7
			if (ev_full) begin
				status[TSB_BIT_FULL_ST] <= 1'b1;                  // RQ2
				status[TSB_BIT_SLIP_ST] <= 1'b1;                  // RQ5
			end
			if (ev_empty) begin
				status[TSB_BIT_EMPTY_ST] <= 1'b1;                 // RQ4
				status[TSB_BIT_SLIP_ST]  <= 1'b1;                 // RQ5
			end
		end
	end

	assign irq = |(status & enable);                          // RQ1 RQ3 RQ5

	// Checks
	property p_full_sets;
		@(posedge clk) disable iff (sys_rst)
		ev_full |=> status[TSB_BIT_FULL_ST] && status[TSB_BIT_SLIP_ST];
	endproperty
	a_full_sets: assert property (p_full_sets) else $error("overflow did not set status"); // RQ2

	property p_empty_sets;
		@(posedge clk) disable iff (sys_rst)
		ev_empty |=> status[TSB_BIT_EMPTY_ST] && status[TSB_BIT_SLIP_ST];
	endproperty
	a_empty_sets: assert property (p_empty_sets) else $error("underflow did not set status"); // RQ4

	property p_drop_frame;
		@(posedge clk) disable iff (sys_rst)
		ev_full && !tx_rd_strobe |=> fill == DEPTH_C - FRAME_C + (AW+1)'(1);
	endproperty
	a_drop_frame: assert property (p_drop_frame) else $error("overflow did not drop a frame"); // RQ2

	property p_replay_frame;
		@(posedge clk) disable iff (sys_rst)
		ev_empty && !tx_wr_strobe |=> fill == FRAME_C - (AW+1)'(1);
	endproperty
	a_replay_frame: assert property (p_replay_frame) else $error("underflow did not replay a frame"); // RQ4

	sequence s_quiet_status_read;
		status_rd && !ev_full && !ev_empty;
	endsequence
	property p_read_clears;
		@(posedge clk) disable iff (sys_rst)
		s_quiet_status_read |=> status == 8'h00;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("status read did not clear"); // RQ7

	property p_full_gate;
		@(posedge clk) disable iff (sys_rst)
		status[TSB_BIT_FULL_ST] && enable[TSB_BIT_FULL_EN] |-> irq;
	endproperty
	a_full_gate: assert property (p_full_gate) else $error("full interrupt not raised"); // RQ1

	property p_empty_gate;
		@(posedge clk) disable iff (sys_rst)
		status[TSB_BIT_EMPTY_ST] && enable[TSB_BIT_EMPTY_EN] |-> irq;
	endproperty
	a_empty_gate: assert property (p_empty_gate) else $error("empty interrupt not raised"); // RQ3

	property p_slip_gate;
		@(posedge clk) disable iff (sys_rst)
		!enable[TSB_BIT_SLIP_EN] && !enable[TSB_BIT_FULL_EN] && !enable[TSB_BIT_EMPTY_EN] |-> !irq;
	endproperty
	a_slip_gate: assert property (p_slip_gate) else $error("interrupt while all disabled"); // RQ5

	property p_reserved_zero;
		@(posedge clk) disable iff (sys_rst)
		rd_go && s_axi_araddr == TSB_ADDR_ENABLE_BYTE |=> s_axi_rdata[4:0] == 5'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable bits not zero"); // RQ6

	property p_drop_while_read;
		@(posedge clk) disable iff (sys_rst)
		ev_full && tx_rd_strobe |=> fill == DEPTH_C - FRAME_C;
	endproperty
	a_drop_while_read: assert property (p_drop_while_read) else $error("overflow with read left wrong fill"); // RQ2

	property p_slip_irq;
		@(posedge clk) disable iff (sys_rst)
		status[TSB_BIT_SLIP_ST] && enable[TSB_BIT_SLIP_EN] |-> irq;
	endproperty
	a_slip_irq: assert property (p_slip_irq) else $error("slip interrupt not raised"); // RQ5

	sequence s_enable_write;
		wr_go && hits_enable(aw_addr) && w_strb[0];
	endsequence
	property p_reserved_store;
		@(posedge clk) disable iff (sys_rst)
		s_enable_write |=> enable[4:0] == 5'h00 && s_axi_bvalid && s_axi_bresp == TSB_RESP_OKAY;
	endproperty
	a_reserved_store: assert property (p_reserved_store) else $error("enable write stored reserved bits"); // RQ6

	sequence s_stray_write;
		wr_go && !hits_enable(aw_addr);
	endsequence
	property p_stray_write;
		@(posedge clk) disable iff (sys_rst)
		s_stray_write |=> s_axi_bvalid && s_axi_bresp == TSB_RESP_SLVERR && $stable(enable);
	endproperty
	a_stray_write: assert property (p_stray_write) else $error("unmapped write not refused");
endmodule // tsb_irq

// *** rtl/tsb_pkg.sv ***
// Package: register map, fields and sizes of the transmit slip buffer interrupt block
package tsb_pkg;
	// Register byte addresses (channel digit of the printed map held apart)
	localparam logic [15:0] TSB_ADDR_ENABLE  = 16'h0b09;
	localparam logic [15:0] TSB_ADDR_ENABLE_BYTE = 16'h0b09 << 2;
	localparam logic [15:0] TSB_ADDR_STATUS  = 16'h0000;
	localparam logic [15:0] TSB_ADDR_DATA    = 16'h0004;
	localparam logic [15:0] TSB_ADDR_FILL    = 16'h0008;
	// Enable register fields
	localparam int TSB_BIT_FULL_EN  = 7;
	localparam int TSB_BIT_EMPTY_EN = 6;
	localparam int TSB_BIT_SLIP_EN  = 5;
	localparam logic [7:0] TSB_ENABLE_RESET = 8'h00;
	localparam logic [7:0] TSB_ENABLE_WMASK = 8'he0;
	// Status register fields, same positions as enables
	localparam int TSB_BIT_FULL_ST  = 7;
	localparam int TSB_BIT_EMPTY_ST = 6;
	localparam int TSB_BIT_SLIP_ST  = 5;
	localparam logic [7:0] TSB_STATUS_RESET = 8'h00;
	// Buffer shape: two frames of 8-bit octets
	localparam int TSB_FRAME_OCTETS = 24;
	localparam int TSB_DEPTH        = 48;
	// AXI answers
	localparam logic [1:0] TSB_RESP_OKAY   = 2'h0;
	localparam logic [1:0] TSB_RESP_SLVERR = 2'h2;
endpackage

// *** tb/tb_tsb_irq.sv ***
// Self-checking bench for the transmit slip buffer interrupt block
`timescale 1ns/1ns
module tb_tsb_irq;
	import tsb_pkg::*;
	localparam logic [15:0] A_EN = TSB_ADDR_ENABLE_BYTE;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [15:0] awaddr = 16'h0000;
	logic [15:0] araddr = 16'h0000;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, v;
	logic [7:0]  wr_data = 8'h00;
	logic [7:0]  rd_data;
	logic        wr_strobe = 1'b0, rd_strobe = 1'b0;
	int          n_mismatch = 0, n_tests = 0;

	always #5 clk = ~clk;

	tsb_irq #(.FRAME(24), .DEPTH(48)) DUT (.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tx_wr_data(wr_data), .tx_wr_strobe(wr_strobe), .tx_rd_strobe(rd_strobe),
		.tx_rd_data(rd_data), .irq(irq));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Handshakes judged at the falling edge, acted on after the rising one
	task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] resp);
		bit aw_ok, w_ok, b_ok;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_ok = 1'b0;
		while (!b_ok) begin
			@(negedge clk);
			aw_ok = awvalid & awready;
			w_ok = wvalid & wready;
			b_ok = bready & bvalid;
			resp = bresp;
			@(posedge clk);
			if (aw_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] resp);
		bit ar_ok, r_ok;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_ok = 1'b0;
		while (!r_ok) begin
			@(negedge clk);
			ar_ok = arvalid & arready;
			r_ok = rvalid & rready;
			d = rdata;
			resp = rresp;
			@(posedge clk);
			if (ar_ok) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk_irq(input logic exp);
		@(negedge clk);
		chk("irq", {31'h0, irq}, {31'h0, exp});
		@(posedge clk);
	endtask

	task automatic push(input int n);
		for (int i = 0; i < n; i++) begin
			wr_strobe <= 1'b1;
			wr_data <= 8'(i);
			@(posedge clk);
		end
		wr_strobe <= 1'b0;
		@(posedge clk);
	endtask

	// Spaced pulls so each octet is seen settled
	task automatic pull(input int n, input int first, input bit check);
		for (int i = 0; i < n; i++) begin
			rd_strobe <= 1'b1;
			@(posedge clk);
			rd_strobe <= 1'b0;
			@(negedge clk);
			if (check) chk("tx_rd_data", {24'h0, rd_data}, 32'(first + i));
			@(posedge clk);
		end
	endtask

	task automatic t_reset();
		axi_rd(A_EN, v, r);
		chk("enable reset", v, 32'h0);
		axi_rd(TSB_ADDR_STATUS, v, r);
		chk("status reset", v, 32'h0);
		chk_irq(1'b0);
	endtask

	task automatic t_regs();
		axi_wr(A_EN, 32'he7, r);
		chk("enable bresp", {30'h0, r}, {30'h0, TSB_RESP_OKAY});
		axi_rd(A_EN, v, r);
		chk("enable reserved", v, 32'he0);
		chk("enable rresp", {30'h0, r}, {30'h0, TSB_RESP_OKAY});
		axi_wr(16'h0100, 32'hff, r);
		chk("unmapped bresp", {30'h0, r}, {30'h0, TSB_RESP_SLVERR});
		axi_rd(16'h0100, v, r);
		chk("unmapped rdata", v, 32'h0);
		chk("unmapped rresp", {30'h0, r}, {30'h0, TSB_RESP_SLVERR});
		axi_wr(A_EN, 32'h00, r);
		axi_rd(A_EN, v, r);
		chk("enable cleared", v, 32'h0);
	endtask

	task automatic t_overflow();
		push(49);
		chk_irq(1'b0);
		axi_rd(TSB_ADDR_FILL, v, r);
		chk("fill after delete", v, 32'd25);
		axi_wr(A_EN, 32'h80, r);
		chk_irq(1'b1);
		axi_rd(TSB_ADDR_STATUS, v, r);
		chk("status overflow", v, 32'ha0);
		chk_irq(1'b0);
		axi_rd(TSB_ADDR_STATUS, v, r);
		chk("status cleared", v, 32'h0);
	endtask

	task automatic t_underflow();
		axi_wr(A_EN, 32'h20, r);
		pull(25, 24, 1'b1);
		chk_irq(1'b0);
		// Replay starts over the frame just sent
		pull(1, 25, 1'b1);
		chk_irq(1'b1);
		pull(23, 26, 1'b1);
		axi_wr(A_EN, 32'h40, r);
		chk_irq(1'b1);
		axi_wr(A_EN, 32'h80, r);
		chk_irq(1'b0);
		axi_rd(TSB_ADDR_STATUS, v, r);
		chk("status underflow", v, 32'h60);
	endtask

	// Overflow and line read in one cycle
	task automatic t_collide();
		push(48);
		wr_strobe <= 1'b1;
		rd_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
		rd_strobe <= 1'b0;
		@(negedge clk);
		chk("tx_rd_data collide", {24'h0, rd_data}, 32'd24);
		@(posedge clk);
		pull(1, 25, 1'b1);
		axi_rd(TSB_ADDR_FILL, v, r);
		chk("fill after collide", v, 32'd23);
		chk_irq(1'b1);
		axi_rd(TSB_ADDR_STATUS, v, r);
		chk("status collide", v, 32'ha0);
	endtask

	task automatic close_out();
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_regs();
		t_overflow();
		t_underflow();
		t_collide();
		close_out();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		close_out();
	end
endmodule // tb_tsb_irq
